// ---- shared/scr_defs.vh ----
// Constants for the reliability-monitoring command responder.
// Assumes a task-file front end that presents decoded register values.
`ifndef SCR_DEFS_VH
`define SCR_DEFS_VH
`define SCR_CMD_SMART     8'hb0
`define SCR_SIG_HI        8'hc2
`define SCR_SIG_LO        8'h4f
`define SCR_BAD_HI        8'h2c
`define SCR_BAD_LO        8'hf4
`define SCR_FEAT_READ     8'hd0
`define SCR_FEAT_THR      8'hd1
`define SCR_FEAT_AUTOSAVE 8'hd2
`define SCR_FEAT_ENABLE   8'hd8
`define SCR_FEAT_DISABLE  8'hd9
`define SCR_FEAT_STATUS   8'hda
`define SCR_AUTOSAVE_OFF  8'h00
`define SCR_AUTOSAVE_ON   8'hf1
`define SCR_VERSION       8'h04
`define SCR_CAPAB         8'h03
`define SCR_VEND_VER      8'h02
`define SCR_ATTR_FLAGS    8'h03
`define SCR_ID_SPARE      8'hc4
`define SCR_ID_ERASE      8'he5
`define SCR_OFS_VER       9'd0
`define SCR_OFS_ATTR      9'd2
`define SCR_ATTR_LEN      9'd12
`define SCR_OFS_ATTR_END  9'd361
`define SCR_OFS_CAPAB     9'd368
`define SCR_OFS_VEND      9'd386
`define SCR_OFS_COMMIT    9'd388
`define SCR_OFS_WLTHR     9'd392
`define SCR_OFS_GWL       9'd396
`define SCR_OFS_GBB       9'd397
`define SCR_OFS_CSUM      9'd511
`define SCR_PCT_FULL      24'd100
`define SCR_EN_RST        1'b0
`endif

// ---- hw/scr_spare_min.v ----
// Spare-block percentage reduction over the four flash chips.
// Assumes spare counts are stable for a cycle; result is registered.
`include "scr_defs.vh"
module scr_spare_min (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire [63:0] init_i,
  input  wire [63:0] cur_i,
  output reg  [7:0]  pct_o,
  output reg  [15:0] min_init_o,
  output reg  [15:0] min_cur_o,
  output reg  [15:0] sum_init_o,
  output reg  [15:0] sum_cur_o
);
  // Chip with no spares at all reports zero, avoiding a divide by zero
  function [7:0] pct;
    input [15:0] cur;
    input [15:0] init;
    reg   [23:0] q;
    begin
      q = 24'h0;
      if (init != 16'h0)
        q = ({8'h0, cur} * `SCR_PCT_FULL) / {8'h0, init};
      pct = (q > `SCR_PCT_FULL) ? 8'd100 : q[7:0];
    end
  endfunction

  reg [7:0]  next_pct;
  reg [15:0] next_init;
  reg [15:0] next_cur;
  reg [15:0] next_sinit;
  reg [15:0] next_scur;
  reg [7:0]  p;
  integer    i;

  // Minimum search; sums wrap at 16 bits like the field they fill
  always @*
  begin
    next_pct   = 8'hff;
    next_init  = 16'h0;
    next_cur   = 16'h0;
    next_sinit = 16'h0;
    next_scur  = 16'h0;
    p          = 8'h0;
    for (i = 0; i < 4; i = i + 1)
    begin
      p = pct(cur_i[16*i +: 16], init_i[16*i +: 16]);
      if (p < next_pct)
      begin
        next_pct  = p;
        next_init = init_i[16*i +: 16];
        next_cur  = cur_i[16*i +: 16];
      end
      next_sinit = next_sinit + init_i[16*i +: 16];
      next_scur  = next_scur + cur_i[16*i +: 16];
    end
  end

  always @(posedge clk_i)
    if (!rst_n_i)
    begin
      pct_o      <= 8'h0;
      min_init_o <= 16'h0;
      min_cur_o  <= 16'h0;
      sum_init_o <= 16'h0;
      sum_cur_o  <= 16'h0;
    end
    else
    begin
      pct_o      <= next_pct;
      min_init_o <= next_init;
      min_cur_o  <= next_cur;
      sum_init_o <= next_sinit;
      sum_cur_o  <= next_scur;
    end
endmodule // scr_spare_min

// ---- hw/scr_sector_byte.v ----
// Combinational byte generator for the data and threshold sectors.
// Assumes the caller supplies the checksum byte itself at offset 511.
`include "scr_defs.vh"
module scr_sector_byte (
  input  wire [8:0]  idx_i,
  input  wire        thr_mode_i,
  input  wire [7:0]  spare_pct_i,
  input  wire [15:0] min_init_i,
  input  wire [15:0] min_cur_i,
  input  wire [15:0] sum_init_i,
  input  wire [15:0] sum_cur_i,
  input  wire [7:0]  life_pct_i,
  input  wire [63:0] erase_total_i,
  input  wire [31:0] commit_i,
  input  wire [31:0] wl_thr_i,
  input  wire [7:0]  spare_thr_i,
  input  wire [7:0]  erase_thr_i,
  input  wire        gwl_i,
  input  wire        gbb_i,
  output reg  [7:0]  byte_o
);
  // Little-endian byte pick, used for every multi-byte field
  function [7:0] lebyte;
    input [63:0] v;
    input [2:0]  k;
    begin
      lebyte = v[{k, 3'b000} +: 8];
    end
  endfunction

  wire [8:0] rel  = idx_i - `SCR_OFS_ATTR;
  wire [8:0] slot = rel / `SCR_ATTR_LEN;
  wire [8:0] off  = rel % `SCR_ATTR_LEN;
  wire [2:0] ofs3 = off[2:0] - 3'd4;

  // Unlisted offsets and unused slots read as zero
  always @*
  begin
    byte_o = 8'h00;
    if (idx_i == `SCR_OFS_VER)
      byte_o = `SCR_VERSION;
    else if (idx_i >= `SCR_OFS_ATTR && idx_i <= `SCR_OFS_ATTR_END)
    begin
      if (thr_mode_i)
      begin
        if (slot == 9'd0 && off == 9'd0) byte_o = `SCR_ID_SPARE;
        if (slot == 9'd0 && off == 9'd1) byte_o = spare_thr_i;
        if (slot == 9'd1 && off == 9'd0) byte_o = `SCR_ID_ERASE;
        if (slot == 9'd1 && off == 9'd1) byte_o = erase_thr_i;
      end
      else if (slot == 9'd0)
        case (off)
          9'd0:        byte_o = `SCR_ID_SPARE;
          9'd1:        byte_o = `SCR_ATTR_FLAGS;
          9'd3:        byte_o = spare_pct_i;
          9'd4, 9'd5:  byte_o = lebyte({48'h0, min_init_i}, {2'b00, off[0]});
          9'd6, 9'd7:  byte_o = lebyte({48'h0, min_cur_i}, {2'b00, off[0]});
          9'd8, 9'd9:  byte_o = lebyte({48'h0, sum_init_i}, {2'b00, off[0]});
          9'd10, 9'd11:
                       byte_o = lebyte({48'h0, sum_cur_i}, {2'b00, off[0]});
          default:     byte_o = 8'h00;
        endcase
      else if (slot == 9'd1)
      begin
        if (off == 9'd0) byte_o = `SCR_ID_ERASE;
        if (off == 9'd1) byte_o = `SCR_ATTR_FLAGS;
        if (off == 9'd3) byte_o = life_pct_i;
        if (off >= 9'd4) byte_o = lebyte(erase_total_i, ofs3);
      end
    end
    else if (!thr_mode_i)
    begin
      if (idx_i == `SCR_OFS_CAPAB) byte_o = `SCR_CAPAB;
      if (idx_i == `SCR_OFS_VEND)  byte_o = `SCR_VEND_VER;
      if (idx_i >= `SCR_OFS_COMMIT && idx_i < `SCR_OFS_WLTHR)
        byte_o = lebyte({32'h0, commit_i}, idx_i[2:0] - 3'd4);
      if (idx_i >= `SCR_OFS_WLTHR && idx_i < `SCR_OFS_GWL)
        byte_o = lebyte({32'h0, wl_thr_i}, idx_i[2:0]);
      if (idx_i == `SCR_OFS_GWL) byte_o = {7'h0, gwl_i};
      if (idx_i == `SCR_OFS_GBB) byte_o = {7'h0, gbb_i};
    end
  end
endmodule // scr_sector_byte

// ---- hw/scr_top.v ----
// Reliability-monitoring command responder: decodes the B0h command
// family, keeps the enable setting, streams the data sectors out.
// Assumes a task-file front end that pulses cmd_valid_i once per
// command with the register values stable, and an NV store that
// presents the saved enable bit at reset and accepts write pulses.
`include "scr_defs.vh"
module scr_top (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        cmd_valid_i,
  input  wire [7:0]  cmd_code_i,
  input  wire [7:0]  feat_i,
  input  wire [7:0]  cyl_hi_i,
  input  wire [7:0]  cyl_lo_i,
  input  wire [7:0]  sec_cnt_i,
  input  wire        data_ready_i,
  input  wire        nv_en_i,
  input  wire [63:0] init_spare_i,
  input  wire [63:0] cur_spare_i,
  input  wire [7:0]  life_pct_i,
  input  wire [63:0] erase_total_i,
  input  wire [31:0] commit_i,
  input  wire [31:0] wl_thr_i,
  input  wire [7:0]  spare_thr_i,
  input  wire [7:0]  erase_thr_i,
  input  wire        gwl_active_i,
  input  wire        gbb_active_i,
  output reg         busy_o,
  output reg         done_o,
  output reg         abort_o,
  output reg         cyl_load_o,
  output reg  [7:0]  cyl_hi_o,
  output reg  [7:0]  cyl_lo_o,
  output reg         data_valid_o,
  output reg  [7:0]  data_o,
  output reg         smart_en_o,
  output reg         nv_wr_o,
  output reg         nv_data_o,
  output reg         thr_exceeded_o
);
  localparam [1:0] ST_BOOT = 2'd0;
  localparam [1:0] ST_IDLE = 2'd1;
  localparam [1:0] ST_SEND = 2'd2;

  reg  [1:0] state;
  reg  [8:0] idx;
  reg  [7:0] sum;
  reg        thr_mode;
  wire [7:0] spare_pct;
  wire [15:0] min_init;
  wire [15:0] min_cur;
  wire [15:0] sum_init;
  wire [15:0] sum_cur;
  wire [7:0] gen_byte;
  wire [8:0] next_idx = idx + 9'd1;
  wire [8:0] gen_idx  = (state == ST_SEND) ? next_idx : `SCR_OFS_VER;
  wire [7:0] next_sum = sum + data_o;
  wire       take     = cmd_valid_i && (cmd_code_i == `SCR_CMD_SMART);
  wire       last     = (idx == `SCR_OFS_CSUM);

  // Host must supply the signature; a wrong one is aborted, not trusted
  wire       sig_ok   = (cyl_hi_i == `SCR_SIG_HI) &&
                        (cyl_lo_i == `SCR_SIG_LO);
  wire       autosave_ok = (sec_cnt_i == `SCR_AUTOSAVE_OFF) ||
                           (sec_cnt_i == `SCR_AUTOSAVE_ON);

  // Either attribute below its threshold marks the device as failing
  wire       exceeded = (spare_pct < spare_thr_i) ||
                        (life_pct_i < erase_thr_i);

  scr_spare_min u_min (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .init_i     (init_spare_i),
    .cur_i      (cur_spare_i),
    .pct_o      (spare_pct),
    .min_init_o (min_init),
    .min_cur_o  (min_cur),
    .sum_init_o (sum_init),
    .sum_cur_o  (sum_cur)
  );

  scr_sector_byte u_byte (
    .idx_i         (gen_idx),
    .thr_mode_i    (thr_mode),
    .spare_pct_i   (spare_pct),
    .min_init_i    (min_init),
    .min_cur_i     (min_cur),
    .sum_init_i    (sum_init),
    .sum_cur_i     (sum_cur),
    .life_pct_i    (life_pct_i),
    .erase_total_i (erase_total_i),
    .commit_i      (commit_i),
    .wl_thr_i      (wl_thr_i),
    .spare_thr_i   (spare_thr_i),
    .erase_thr_i   (erase_thr_i),
    .gwl_i         (gwl_active_i),
    .gbb_i         (gbb_active_i),
    .byte_o        (gen_byte)
  );

  // Status flag tracks the attributes continuously
  always @(posedge clk_i)
    if (!rst_n_i)
      thr_exceeded_o <= 1'b0;
    else
      thr_exceeded_o <= exceeded;

  // Command sequencer; the stored enable bit is caught the cycle
  // after reset releases, so reset itself only loads a constant
  always @(posedge clk_i)
    if (!rst_n_i)
    begin
      state        <= ST_BOOT;
      busy_o       <= 1'b1;
      done_o       <= 1'b0;
      abort_o      <= 1'b0;
      cyl_load_o   <= 1'b0;
      cyl_hi_o     <= 8'h00;
      cyl_lo_o     <= 8'h00;
      data_valid_o <= 1'b0;
      data_o       <= 8'h00;
      smart_en_o   <= `SCR_EN_RST;
      nv_wr_o      <= 1'b0;
      nv_data_o    <= 1'b0;
      idx          <= 9'h000;
      sum          <= 8'h00;
      thr_mode     <= 1'b0;
    end
    else
    begin
      done_o     <= 1'b0;
      abort_o    <= 1'b0;
      cyl_load_o <= 1'b0;
      nv_wr_o    <= 1'b0;
      case (state)
        ST_BOOT:
        begin
          smart_en_o <= nv_en_i;
          busy_o     <= 1'b0;
          state      <= ST_IDLE;
        end
        ST_IDLE:
          if (take)
          begin
            if (!sig_ok)
              abort_o <= 1'b1;
            else if (!smart_en_o && feat_i != `SCR_FEAT_ENABLE)
              abort_o <= 1'b1; // Disabled feature set rejects the rest
            else
              case (feat_i)
                `SCR_FEAT_ENABLE, `SCR_FEAT_DISABLE:
                begin
                  smart_en_o <= (feat_i == `SCR_FEAT_ENABLE);
                  nv_wr_o    <= 1'b1;
                  nv_data_o  <= (feat_i == `SCR_FEAT_ENABLE);
                  done_o     <= 1'b1;
                end
                `SCR_FEAT_AUTOSAVE:
                begin
                  // Data is always current, so nothing is saved
                  done_o  <= autosave_ok;
                  abort_o <= !autosave_ok;
                end
                `SCR_FEAT_READ, `SCR_FEAT_THR:
                begin
                  thr_mode     <= (feat_i == `SCR_FEAT_THR);
                  idx          <= `SCR_OFS_VER;
                  data_o       <= gen_byte;
                  data_valid_o <= 1'b1;
                  sum          <= 8'h00;
                  busy_o       <= 1'b1;
                  state        <= ST_SEND;
                end
                `SCR_FEAT_STATUS:
                begin
                  cyl_hi_o   <= exceeded ? `SCR_BAD_HI : `SCR_SIG_HI;
                  cyl_lo_o   <= exceeded ? `SCR_BAD_LO : `SCR_SIG_LO;
                  cyl_load_o <= 1'b1;
                  done_o     <= 1'b1;
                end
                default:
                  abort_o <= 1'b1;
              endcase
          end
        ST_SEND:
          // One byte moves per accepted handshake; new commands are ignored
          if (data_ready_i)
          begin
            sum <= next_sum;
            if (last)
            begin
              data_valid_o <= 1'b0;
              busy_o       <= 1'b0;
              done_o       <= 1'b1;
              state        <= ST_IDLE;
            end
            else
            begin
              idx <= next_idx;
              if (next_idx == `SCR_OFS_CSUM)
                data_o <= 8'h00 - next_sum;
              else
                data_o <= gen_byte;
            end
          end
        default:
          state <= ST_IDLE;
      endcase
    end
endmodule // scr_top

// ---- testbench/scr_top_properties.sv ----
// Concurrent checks on the responder's command and stream ports.
// Assumes one clock domain and the synchronous active-low reset.
`include "scr_defs.vh"
module scr_top_properties (
  input wire       clk_i,
  input wire       rst_n_i,
  input wire       cmd_valid_i,
  input wire [7:0] cmd_code_i,
  input wire [7:0] feat_i,
  input wire [7:0] cyl_hi_i,
  input wire [7:0] cyl_lo_i,
  input wire [7:0] sec_cnt_i,
  input wire       data_ready_i,
  input wire [7:0] life_pct_i,
  input wire [7:0] erase_thr_i,
  input wire       busy_o,
  input wire       done_o,
  input wire       abort_o,
  input wire       cyl_load_o,
  input wire [7:0] cyl_hi_o,
  input wire [7:0] cyl_lo_o,
  input wire       data_valid_o,
  input wire [7:0] data_o,
  input wire       smart_en_o,
  input wire       nv_wr_o,
  input wire       nv_data_o,
  input wire       thr_exceeded_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Request accepted by an idle responder, signature aside
  wire req  = cmd_valid_i && cmd_code_i == `SCR_CMD_SMART && !busy_o;
  wire sig  = cyl_hi_i == `SCR_SIG_HI && cyl_lo_i == `SCR_SIG_LO;
  wire take = req && sig;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_enable_sets:
    assert property (take && feat_i == `SCR_FEAT_ENABLE
      |=> done_o && nv_wr_o && nv_data_o && smart_en_o)
    else $error("enable not applied");
  a_disable_clears:
    assert property (take && smart_en_o && feat_i == `SCR_FEAT_DISABLE
      |=> done_o && nv_wr_o && !nv_data_o && !smart_en_o)
    else $error("disable not applied");
  a_autosave_noop:
    assert property (take && smart_en_o && feat_i == `SCR_FEAT_AUTOSAVE &&
      (sec_cnt_i == 8'h00 || sec_cnt_i == 8'hf1)
      |=> done_o && !abort_o && $stable(smart_en_o) && !data_valid_o)
    else $error("autosave had an effect");
  a_bad_feature:
    assert property (take && smart_en_o && !(feat_i inside {8'hd0, 8'hd1,
      8'hd2, 8'hd8, 8'hd9, 8'hda}) |=> abort_o && !done_o)
    else $error("unsupported feature not aborted");
  a_bad_signature:
    assert property (req && !sig |=> abort_o && !done_o)
    else $error("wrong signature not aborted");
  a_foreign_ignored:
    assert property (cmd_valid_i && cmd_code_i != `SCR_CMD_SMART && !busy_o
      |=> !done_o && !abort_o)
    else $error("foreign command answered");
  a_read_opens:
    assert property (take && smart_en_o && feat_i == `SCR_FEAT_READ
      |=> data_valid_o && busy_o && data_o == `SCR_VERSION)
    else $error("read sector did not open with version");
  a_stream_holds:
    assert property (data_valid_o && !data_ready_i
      |=> data_valid_o && $stable(data_o))
    else $error("byte dropped while stalled");
  a_status_worn:
    assert property (take && smart_en_o && feat_i == `SCR_FEAT_STATUS &&
      life_pct_i < erase_thr_i |=> cyl_load_o && done_o &&
      cyl_lo_o == `SCR_BAD_LO && cyl_hi_o == `SCR_BAD_HI)
    else $error("worn status not reported");
  a_life_flag:
    assert property (life_pct_i < erase_thr_i |=> thr_exceeded_o)
    else $error("life threshold flag missing");
endmodule // scr_top_properties

bind scr_top scr_top_properties u_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
  .cmd_code_i(cmd_code_i), .feat_i(feat_i), .cyl_hi_i(cyl_hi_i),
  .cyl_lo_i(cyl_lo_i), .sec_cnt_i(sec_cnt_i), .data_ready_i(data_ready_i),
  .life_pct_i(life_pct_i), .erase_thr_i(erase_thr_i), .busy_o(busy_o),
  .done_o(done_o), .abort_o(abort_o), .cyl_load_o(cyl_load_o),
  .cyl_hi_o(cyl_hi_o), .cyl_lo_o(cyl_lo_o), .data_valid_o(data_valid_o),
  .data_o(data_o), .smart_en_o(smart_en_o), .nv_wr_o(nv_wr_o),
  .nv_data_o(nv_data_o), .thr_exceeded_o(thr_exceeded_o));

// ---- testbench/scr_host_sink.sv ----
// Host side of the sector stream: accepts bytes and keeps the last sector.
// Assumes the bench reads mem and count after each transfer completes.
module scr_host_sink (
  input  wire       clk_i,
  input  wire       data_valid_i,
  input  wire [7:0] data_i,
  input  wire       stall_i,
  output logic      data_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [512];
  logic [15:0] count = 16'h0000;
  logic [1:0]  phase = 2'h0;
  // Slow mode takes one byte in four, to exercise the hold path
  initial data_ready_o = 1'b0;
  always @(negedge clk_i)
  begin
    phase <= phase + 2'h1;
    data_ready_o <= !stall_i || phase == 2'h3;
  end
  // Host view of the minimum chip's initial spare count; a layout
  // vendor version word of zero means the count arrived byte-swapped
  wire        swap = {mem[387], mem[386]} == 16'h0000;
  wire [15:0] spare_init = swap ? {mem[6], mem[7]} : {mem[7], mem[6]};
  // Bytes are kept in order of arrival, one per accepted handshake
  always @(posedge clk_i)
    if (data_valid_i && data_ready_o)
    begin
      mem[count[8:0]] <= data_i;
      count <= count + 16'h0001;
    end
endmodule // scr_host_sink

// ---- testbench/tb_scr_top.sv ----
// Self-checking bench for the responder: commands, sectors, status.
// Assumes the host sink model and the property checker bound to dut.
`include "scr_defs.vh"
module tb_scr_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 0, rst_n_i = 0, cmd_valid_i = 0, nv_en_i = 0;
  logic [7:0]  cmd_code_i = 0, feat_i = 0, cyl_hi_i = 0, cyl_lo_i = 0;
  logic [7:0]  sec_cnt_i = 0, life_pct_i = 8'h5a;
  logic [7:0]  spare_thr_i = 8'h14, erase_thr_i = 8'h10;
  logic [63:0] init_spare_i = 64'h0028_0064_0032_0050;
  logic [63:0] cur_spare_i = 64'h001e_005a_0014_003c;
  logic [63:0] erase_total_i = 64'h0102030405060708;
  logic [31:0] commit_i = 32'h11223344, wl_thr_i = 32'h55667788;
  logic        gwl_active_i = 1, gbb_active_i = 0, stall = 0;
  wire         data_ready_i, busy_o, done_o, abort_o, cyl_load_o;
  wire         data_valid_o, smart_en_o, nv_wr_o, nv_data_o, thr_exceeded_o;
  wire [7:0]   cyl_hi_o, cyl_lo_o, data_o;
  int          fail_count = 0, cmp_count = 0;
  // Expected data sector bytes; chip 1 gives the minimum of 40 percent
  int          ofs [30] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13,
    14, 15, 16, 17, 18, 25, 362, 368, 369, 373, 386, 388, 391, 392, 396, 397};
  logic [7:0]  val [30] = '{8'h04, 8'h00, 8'hc4, 8'h03, 8'h00, 8'h28, 8'h32,
    8'h00, 8'h14, 8'h00, 8'h0e, 8'h01, 8'hc8, 8'h00, 8'he5, 8'h03, 8'h00,
    8'h5a, 8'h08, 8'h01, 8'h00, 8'h03, 8'h00, 8'h00, 8'h02, 8'h44, 8'h11,
    8'h88, 8'h01, 8'h00};
  logic [7:0]  bad [4] = '{8'h00, 8'hd3, 8'hdb, 8'hff};
  // Spare threshold, erase threshold, expected low and high signature
  logic [7:0]  st [3][4] = '{'{8'h14, 8'h10, 8'h4f, 8'hc2},
    '{8'h29, 8'h10, 8'hf4, 8'h2c}, '{8'h14, 8'h5b, 8'hf4, 8'h2c}};

  always #5 clk_i = ~clk_i;

  scr_top dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
    .cmd_code_i(cmd_code_i), .feat_i(feat_i), .cyl_hi_i(cyl_hi_i),
    .cyl_lo_i(cyl_lo_i), .sec_cnt_i(sec_cnt_i), .data_ready_i(data_ready_i),
    .nv_en_i(nv_en_i), .init_spare_i(init_spare_i), .cur_spare_i(cur_spare_i),
    .life_pct_i(life_pct_i), .erase_total_i(erase_total_i),
    .commit_i(commit_i), .wl_thr_i(wl_thr_i), .spare_thr_i(spare_thr_i),
    .erase_thr_i(erase_thr_i), .gwl_active_i(gwl_active_i),
    .gbb_active_i(gbb_active_i), .busy_o(busy_o), .done_o(done_o),
    .abort_o(abort_o), .cyl_load_o(cyl_load_o), .cyl_hi_o(cyl_hi_o),
    .cyl_lo_o(cyl_lo_o), .data_valid_o(data_valid_o), .data_o(data_o),
    .smart_en_o(smart_en_o), .nv_wr_o(nv_wr_o), .nv_data_o(nv_data_o),
    .thr_exceeded_o(thr_exceeded_o));

  scr_host_sink host (
    .clk_i(clk_i), .data_valid_i(data_valid_o), .data_i(data_o),
    .stall_i(stall), .data_ready_o(data_ready_i));

  task chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task conclude;
    if (fail_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Reset, then wait three cycles for the boot cycle after release to load the saved enable bit
  task rst(input logic nv);
    rst_n_i = 0;
    nv_en_i = nv;
    repeat (20) @(negedge clk_i);
    rst_n_i = 1;
    repeat (3) @(negedge clk_i);
  endtask

  // One-cycle command pulse, answer checked the cycle after
  task op(input logic [7:0] f, input logic [1:0] e,
          input logic [7:0] s = 8'h00, input logic [7:0] hi = `SCR_SIG_HI,
          input logic [7:0] lo = `SCR_SIG_LO,
          input logic [7:0] code = `SCR_CMD_SMART);
    @(negedge clk_i);
    {cmd_valid_i, feat_i, sec_cnt_i, cyl_hi_i, cyl_lo_i} = {1'b1, f, s, hi, lo};
    cmd_code_i = code;
    @(negedge clk_i);
    cmd_valid_i = 0;
    if (e != 2'b11)
      chk("response", {done_o, abort_o}, e);
  endtask

  // Sector read; the bounded wait guards against a missing done pulse
  task rd(input logic [7:0] f, input logic s);
    logic [15:0] base;
    logic [7:0]  sum;
    base = host.count;
    sum = 8'h00;
    stall = s;
    op(f, 2'b11);
    for (int i = 0; i < 3000 && done_o !== 1'b1; i++) @(negedge clk_i);
    chk("byte count", host.count - base, 64'd512);
    for (int i = 0; i < 512; i++) sum = sum + host.mem[i];
    chk("checksum", sum, 8'h00);
  endtask

  initial
  begin
    #200000;
    fail_count++;
    conclude;
  end

  initial
  begin
    rst(1);
    chk("enable after reset", smart_en_o, 1'b1);
    op(`SCR_FEAT_DISABLE, 2'b10);
    chk("disable", {nv_wr_o, nv_data_o, smart_en_o}, 3'b100);
    rst(0);
    chk("disabled after reset", smart_en_o, 1'b0);
    op(`SCR_FEAT_READ, 2'b01);
    op(`SCR_FEAT_ENABLE, 2'b10);
    chk("enable", {nv_wr_o, nv_data_o, smart_en_o}, 3'b111);
    op(`SCR_FEAT_AUTOSAVE, 2'b10, `SCR_AUTOSAVE_OFF);
    op(`SCR_FEAT_AUTOSAVE, 2'b10, `SCR_AUTOSAVE_ON);
    op(`SCR_FEAT_AUTOSAVE, 2'b01, 8'h12);
    chk("autosave kept enable", smart_en_o, 1'b1);
    foreach (bad[i]) op(bad[i], 2'b01);
    op(`SCR_FEAT_READ, 2'b01, 8'h00, 8'h00);
    op(`SCR_FEAT_READ, 2'b00, 8'h00, `SCR_SIG_HI, `SCR_SIG_LO, 8'hec);
    rd(`SCR_FEAT_READ, 1'b1);
    foreach (ofs[i]) chk("data byte", host.mem[ofs[i]], val[i]);
    // Must precede the threshold read, which leaves a zero vendor version word
    chk("host spare count", host.spare_init, 64'h0032);
    rd(`SCR_FEAT_THR, 1'b0);
    chk("threshold sector", {host.mem[0], host.mem[2], host.mem[3],
      host.mem[14], host.mem[15]}, 40'h04c414e510);
    // Thresholds settle for a few cycles since the flag lags its inputs
    foreach (st[i])
    begin
      @(negedge clk_i);
      {spare_thr_i, erase_thr_i} = {st[i][0], st[i][1]};
      repeat (3) @(negedge clk_i);
      op(`SCR_FEAT_STATUS, 2'b10);
      chk("status", {cyl_load_o, cyl_lo_o, cyl_hi_o}, {1'b1, st[i][2], st[i][3]});
      chk("exceeded", thr_exceeded_o, st[i][2] == 8'hf4);
    end
    conclude;
  end
endmodule // tb_scr_top
